// ===== logic/acs_cfg.svh
// Notes on behaviour
// R01 - Config 0/1 selects two fully differential pairs
// R02 - Config 1/0 selects pseudo-differential pairs, minus offset
// R03 - Sequencing 00 is manual channel selection
// R04 - Host writes channel address before conversion
// R05 - Each write picks next channel; no auto-advance
// R06 - Differential span maps to full code range
// R07 - Doubled range spans two times reference
// R08 - Config 00 gives four single-ended channels
// R09 - Sequencing 11 counts zero to address, wraps
// R10 - Falling start edge samples selected channel
// R11 - Fields hold until write, apply next conversion
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register map, byte addresses on the plain port
`define ACS_ADDR_W 8
`define ACS_DATA_W 16
`define ACS_ADDR_CTRL 8'h00
`define ACS_ADDR_STAT 8'h04

// Control word field positions
`define ACS_CFG_LO_POS 0
`define ACS_CFG_HI_POS 1
`define ACS_SEQ_LO_POS 2
`define ACS_SEQ_HI_POS 3
`define ACS_ADR_LO_POS 4
`define ACS_ADR_HI_POS 5
`define ACS_RANGE_POS 6
`define ACS_CTRL_W 7
`define ACS_CTRL_RST 7'h00

// Status word field positions
`define ACS_STAT_CHAN_POS 0
`define ACS_STAT_PTR_POS 2
`define ACS_STAT_PAIR_POS 4
`define ACS_STAT_CNT_POS 8
`define ACS_CNT_W 8

// Code mapping: input counts of reference/4096, offsets of the spans
`define ACS_DIFF_W 15
`define ACS_CODE_W 12
`define ACS_SPAN_1X 16'h1000
`define ACS_SPAN_2X 16'h2000
`define ACS_CODE_MAX 16'h0FFF

`endif

// ===== logic/acs_code_map.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_code_map (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic signed [`ACS_DIFF_W-1:0] diff_i,
    input wire logic diff_valid_i,
    input wire logic bipolar_i,
    input wire logic range_x2_i,
    input wire logic res_10bit_i,
    output logic [`ACS_CODE_W-1:0] code_o,
    output logic code_valid_o
);
    import acs_pkg::*;

    // Registered state of the mapper
    typedef struct packed {
        logic [`ACS_CODE_W-1:0] code;
        logic valid;
    } acs_map_st_t;

    acs_map_st_t st_r;
    acs_map_st_t st_nxt;
    logic signed [15:0] shifted;
    logic signed [15:0] scaled;
    logic [15:0] clamped;

    // Clamp into the legal code window
    function automatic logic [15:0] clamp_code(input logic signed [15:0] v);
        if (v < 0) begin
            clamp_code = 16'h0000;
        end else if (v > $signed(`ACS_CODE_MAX)) begin
            clamp_code = `ACS_CODE_MAX;
        end else begin
            clamp_code = v;
        end
    endfunction

    // Offset bipolar input by the span, then shift right once for bipolar and once for x2 range
    always_comb begin
        st_nxt = st_r;
        shifted = 16'(diff_i);
        if (bipolar_i) begin
            shifted = 16'(diff_i) + $signed(range_x2_i ? `ACS_SPAN_2X : `ACS_SPAN_1X); // R06
        end
        // Bipolar halves for the two-sided span; x2 range halves once more
        scaled = shifted >>> (32'(bipolar_i) + 32'(range_x2_i)); // R07
        clamped = clamp_code(scaled);
        st_nxt.valid = diff_valid_i;
        if (diff_valid_i) begin
            // The short variant keeps the top ten bits only
            st_nxt.code = res_10bit_i ? 12'(clamped >> 2) : clamped[11:0];
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign code_o = st_r.code;
    assign code_valid_o = st_r.valid;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_code_midscale: assert property (diff_valid_i && bipolar_i && diff_i == 0 // R06
        && !res_10bit_i |=> code_o == 12'h0800)
        else $error("differential zero not at midscale");
    chk_code_x2_bottom: assert property (diff_valid_i && bipolar_i && range_x2_i // R07
        && diff_i == -15'sd8192 |=> code_o == 12'h0000)
        else $error("x2 bottom not zero");
    chk_code_valid: assert property (diff_valid_i |=> code_valid_o)
        else $error("code valid missing");
endmodule

// ===== logic/acs_input_select.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_input_select (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [`ACS_ADDR_W-1:0] reg_addr_i,
    input wire logic [`ACS_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`ACS_DATA_W-1:0] reg_rdata_o,
    input wire logic conversion_start_n_i,
    input wire logic res_10bit_i,
    output logic sample_o,
    output acs_pkg::acs_mux_t mux_o,
    input wire logic signed [`ACS_DIFF_W-1:0] diff_i,
    input wire logic diff_valid_i,
    output logic [`ACS_CODE_W-1:0] code_o,
    output logic code_valid_o
);
    import acs_pkg::*;

    // Whole state of the selector
    typedef struct packed {
        acs_ctrl_t ctrl;
        logic [1:0] seq_ptr;
        logic start_prev;
        logic sample;
        acs_mux_t mux;
        logic [`ACS_CNT_W-1:0] conv_cnt;
        logic [`ACS_DATA_W-1:0] rdata;
    } acs_st_t;

    acs_st_t st_r;
    acs_st_t st_nxt;
    logic start_fall; // Falling edge of the start input
    logic ctrl_wr; // Write to the control word
    logic [1:0] conv_chan; // Channel used by this conversion
    logic seq_auto; // Consecutive sequencing selected

    // Steering for one channel under one pairing
    function automatic acs_mux_t decode_mux(input acs_ctrl_t c, input logic [1:0] ch);
        acs_mux_t m;
        m = '0;
        m.chan = ch;
        m.range_x2 = c.range_x2;
        case (acs_cfg_t'(c.input_cfg))
            ACS_DIFF, ACS_PSEUDO: begin
                // Pairs sit on inputs 0/1 and 2/3; only the low address bit counts
                m.pair_mode = 1'b1; // R01
                m.pseudo = (c.input_cfg == ACS_PSEUDO); // R02
                m.pos_sel = {ch[0], 1'b0};
                m.neg_sel = {ch[0], 1'b1};
            end
            default: begin
                // Single-ended; reserved pairing falls back here as the safe choice
                m.neg_to_gnd = 1'b1; // R08
                m.pos_sel = ch;
                m.neg_sel = 2'h0;
            end
        endcase
        decode_mux = m;
    endfunction

    // Next sequencer position, wrapping after the addressed channel
    function automatic logic [1:0] next_ptr(input logic [1:0] p, input logic [1:0] last);
        next_ptr = (p >= last) ? 2'h0 : 2'(p + 2'h1);
    endfunction

    // Status word: channel, pointer, pairing and conversion count
    function automatic logic [`ACS_DATA_W-1:0] stat_word(input acs_st_t s);
        logic [`ACS_DATA_W-1:0] w;
        w = '0;
        w[`ACS_STAT_CHAN_POS +: 2] = s.mux.chan;
        w[`ACS_STAT_PTR_POS +: 2] = s.seq_ptr;
        w[`ACS_STAT_PAIR_POS] = s.mux.pair_mode;
        w[`ACS_STAT_CNT_POS +: `ACS_CNT_W] = s.conv_cnt;
        stat_word = w;
    endfunction

    // Detector starts high, so a line already low at reset release counts as a start
    assign start_fall = st_r.start_prev & ~conversion_start_n_i; // R10
    // Writes to any other address are ignored
    assign ctrl_wr = reg_wr_i && (reg_addr_i == `ACS_ADDR_CTRL);
    assign seq_auto = (st_r.ctrl.seq_mode == 2'h3);
    // Manual and the two unlisted sequencing codes use the address directly
    assign conv_chan = seq_auto ? st_r.seq_ptr : st_r.ctrl.chan_addr; // R03 R05

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.start_prev = conversion_start_n_i;
        st_nxt.sample = start_fall;
        st_nxt.rdata = '0;

        // Conversion start uses the fields as they stood before any same-cycle write
        if (start_fall) begin
            st_nxt.mux = decode_mux(st_r.ctrl, conv_chan); // R10
            st_nxt.conv_cnt = st_r.conv_cnt + 8'h01;
            if (seq_auto) begin
                st_nxt.seq_ptr = next_ptr(st_r.seq_ptr, st_r.ctrl.chan_addr); // R09
            end
        end

        // Control word write; the host sets the address ahead of the conversion
        if (ctrl_wr) begin
            st_nxt.ctrl = acs_ctrl_t'(reg_wdata_i[`ACS_CTRL_W-1:0]); // R04
            // A write restarts any sequence at channel zero
            st_nxt.seq_ptr = 2'h0; // R09
        end

        // Read decode; unmapped addresses read as zero
        if (reg_rd_i) begin
            if (reg_addr_i == `ACS_ADDR_CTRL) begin
                st_nxt.rdata = {{(`ACS_DATA_W-`ACS_CTRL_W){1'b0}}, st_r.ctrl};
            end else if (reg_addr_i == `ACS_ADDR_STAT) begin
                st_nxt.rdata = stat_word(st_r);
            end else begin
                st_nxt.rdata = '0;
            end
        end
    end

    // State register; fields only change on a write
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.ctrl <= `ACS_CTRL_RST;
            st_r.start_prev <= 1'b1;
            st_r.mux.neg_to_gnd <= 1'b1;
        end else begin
            st_r <= st_nxt; // R11
        end
    end

    // Code mapping of the converted difference, with the pairing of that sample
    acs_code_map u_code_map (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .diff_i(diff_i),
        .diff_valid_i(diff_valid_i),
        .bipolar_i(st_r.mux.pair_mode && !st_r.mux.pseudo),
        .range_x2_i(st_r.mux.range_x2),
        .res_10bit_i(res_10bit_i),
        .code_o(code_o),
        .code_valid_o(code_valid_o)
    );

    assign reg_rdata_o = st_r.rdata;
    assign sample_o = st_r.sample;
    assign mux_o = st_r.mux;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Start edge: line was high last cycle and is low now
    sequence s_start_edge;
        st_r.start_prev && !conversion_start_n_i;
    endsequence

    sequence s_no_write;
        !ctrl_wr;
    endsequence

    // Manual sample with no control write in that same cycle
    sequence s_manual_sample;
        sample_o && !ctrl_wr && st_r.ctrl.seq_mode == 2'h0;
    endsequence

    // Start edge handshake
    chk_sample_on_fall: assert property (s_start_edge |=> sample_o) // R10
        else $error("no sample after start edge");
    chk_sample_cause: assert property (sample_o |-> $past(start_fall)) // R10
        else $error("sample without start edge");

    // Pairing of the inputs at each start edge
    chk_diff_pairs: assert property (s_start_edge ##0 (st_r.ctrl.input_cfg == 2'h2) // R01
        |=> mux_o.pair_mode && !mux_o.pseudo && mux_o.neg_sel == {mux_o.chan[0], 1'b1})
        else $error("differential pairing wrong");
    chk_pseudo_pairs: assert property (s_start_edge ##0 (st_r.ctrl.input_cfg == 2'h1) // R02
        |=> mux_o.pair_mode && mux_o.pseudo && !mux_o.neg_to_gnd)
        else $error("pseudo pairing wrong");
    chk_single_gnd: assert property (s_start_edge ##0 (st_r.ctrl.input_cfg == 2'h0) // R08
        |=> mux_o.neg_to_gnd && mux_o.pos_sel == mux_o.chan)
        else $error("single-ended minus not grounded");

    // Channel choice in manual and sequenced modes
    chk_manual_chan: assert property (s_start_edge ##0 (st_r.ctrl.seq_mode == 2'h0) // R03
        |=> mux_o.chan == $past(st_r.ctrl.chan_addr))
        else $error("manual channel not the address");
    chk_manual_hold: assert property (s_manual_sample ##0 !$past(ctrl_wr) // R05
        ##1 s_no_write [*2] ##1 s_start_edge |=> mux_o.chan == $past(mux_o.chan, 4))
        else $error("manual channel advanced");
    chk_seq_restart: assert property (ctrl_wr |=> st_r.seq_ptr == 2'h0) // R09
        else $error("write did not restart sequence");
    chk_seq_step: assert property (s_start_edge ##0 s_no_write ##0 seq_auto // R09
        |=> st_r.seq_ptr == ($past(st_r.seq_ptr) >= $past(st_r.ctrl.chan_addr)
            ? 2'h0 : $past(st_r.seq_ptr) + 2'h1))
        else $error("sequence step wrong");
    // Sequenced conversions take the pointer, so the first after a write is channel 0
    chk_seq_chan: assert property (s_start_edge ##0 seq_auto // R09
        |=> mux_o.chan == $past(st_r.seq_ptr))
        else $error("sequenced channel not the pointer");

    // Fields and steering hold between writes and starts
    chk_fields_hold: assert property (s_no_write |=> $stable(st_r.ctrl)) // R11
        else $error("fields changed without write");
    chk_mux_hold: assert property (!start_fall |=> $stable(mux_o)) // R11
        else $error("steering changed between conversions");
    // Range bit carried into the steering of the next sample
    chk_range_follow: assert property (s_start_edge // R07
        |=> mux_o.range_x2 == $past(st_r.ctrl.range_x2))
        else $error("range bit not applied");

    // Register port: read back, idle zero, conversion count
    chk_ctrl_read: assert property (reg_rd_i && reg_addr_i == `ACS_ADDR_CTRL
        |=> reg_rdata_o[`ACS_CTRL_W-1:0] == $past(st_r.ctrl))
        else $error("control read back wrong");
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero when idle");
    chk_count_step: assert property (s_start_edge
        |=> st_r.conv_cnt == 8'($past(st_r.conv_cnt) + 8'h01))
        else $error("conversion count step wrong");
endmodule

// ===== logic/acs_pkg.sv
package acs_pkg;
    `include "acs_cfg.svh"

    // Decoded input pairing
    typedef enum logic [1:0] {
        ACS_SINGLE = 2'h0,
        ACS_PSEUDO = 2'h1,
        ACS_DIFF = 2'h2,
        ACS_RSVD = 2'h3
    } acs_cfg_t;

    // Control register image
    typedef struct packed {
        logic range_x2;
        logic [1:0] chan_addr;
        logic [1:0] seq_mode;
        logic [1:0] input_cfg;
    } acs_ctrl_t;

    // Multiplexer steering towards the analog front end
    typedef struct packed {
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        logic neg_to_gnd;
        logic pair_mode;
        logic pseudo;
        logic range_x2;
        logic [1:0] chan;
    } acs_mux_t;
endpackage

// ===== testbench/acs_host_model.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
// Host processor: writes control, reads back, strobes the start line
module acs_host_model (
    input wire logic ref_clk_i,
    input wire logic [`ACS_DATA_W-1:0] reg_rdata_i,
    output logic [`ACS_ADDR_W-1:0] reg_addr_o,
    output logic [`ACS_DATA_W-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic conversion_start_n_o
);
    // Idle levels at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        conversion_start_n_o = 1'b1;
    end

    // One-cycle write; address and data scrambled afterwards so stale values never help
    task automatic wr_ctrl(input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= `ACS_ADDR_CTRL;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~reg_addr_o;
        reg_wdata_o <= ~reg_wdata_o;
    endtask

    // One-cycle read; data taken in the cycle after the strobe only
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] q);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~reg_addr_o;
        #1;
        q = reg_rdata_i;
    endtask

    // Falling edge starts a conversion; line back high before the next one
    task automatic convert();
        @(posedge ref_clk_i);
        conversion_start_n_o <= 1'b0;
        @(posedge ref_clk_i);
        conversion_start_n_o <= 1'b1;
        #1;
    endtask
endmodule

// ===== testbench/test_adc_input_channel_select.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
// Bench: random control words over every pairing and sequencing mode
module test_adc_input_channel_select;
    import acs_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic conversion_start_n_i;
    logic res_10bit_i = 1'b0;
    logic sample_o;
    acs_mux_t mux_o;
    logic signed [14:0] diff_i = 15'h0000;
    logic diff_valid_i = 1'b0;
    logic [11:0] code_o;
    logic code_valid_o;
    int num_errors = 0;
    int checks_done = 0;

    // 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    acs_input_select dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .conversion_start_n_i(conversion_start_n_i), .res_10bit_i(res_10bit_i),
        .sample_o(sample_o), .mux_o(mux_o), .diff_i(diff_i), .diff_valid_i(diff_valid_i),
        .code_o(code_o), .code_valid_o(code_valid_o));

    acs_host_model host_u (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .conversion_start_n_o(conversion_start_n_i));

    // Single comparison point
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reference code mapping; clamps before the 10-bit shift
    function automatic logic [15:0] exp_code(int d, logic dif, logic rg, logic r10);
        int v;
        if (dif) begin
            v = rg ? (d + 8192) / 4 : (d + 4096) / 2;
        end else begin
            v = rg ? d / 2 : d;
        end
        if (v < 0) v = 0;
        if (v > 4095) v = 4095;
        if (r10) v = v >> 2;
        return 16'(v);
    endfunction

    // Watchdog well beyond the expected run
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        acs_ctrl_t ctl;
        acs_mux_t em;
        logic [15:0] q;
        logic [1:0] ptr;
        logic [1:0] ch;
        int d;
        int n_conv;
        int code_q[$];
        void'($urandom(32'h9e76_4a35));
        n_conv = 0;
        em = '0;
        em.neg_to_gnd = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        host_u.rd_reg(`ACS_ADDR_CTRL, q);
        check("ctrl_reset", q, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            ctl = 7'($urandom);
            ctl.seq_mode = k[3:2];
            ctl.input_cfg = k[1:0];
            res_10bit_i <= 1'($urandom);
            host_u.wr_ctrl({9'h000, ctl});
            ptr = 2'h0;
            @(posedge ref_clk_i);
            #1;
            check("mux_hold", {6'h00, mux_o}, {6'h00, em});
            host_u.rd_reg(`ACS_ADDR_CTRL, q);
            check("ctrl_back", q, {9'h000, ctl});
            // Read data stand one cycle only; unmapped reads give zero
            @(posedge ref_clk_i);
            #1;
            check("rdata_idle", reg_rdata_o, 16'h0000);
            host_u.rd_reg(8'h08, q);
            check("unmapped", q, 16'h0000);
            repeat (5) begin
                // Manual picks the address; sequence walks 0..address and wraps
                ch = (ctl.seq_mode == 2'h3) ? ptr : ctl.chan_addr;
                if (ctl.seq_mode == 2'h3) ptr = (ptr == ctl.chan_addr) ? 2'h0 : ptr + 2'h1;
                em = '0;
                em.chan = ch;
                em.range_x2 = ctl.range_x2;
                if (ctl.input_cfg == 2'h1 || ctl.input_cfg == 2'h2) begin
                    em.pair_mode = 1'b1;
                    em.pseudo = (ctl.input_cfg == 2'h1);
                    em.pos_sel = {ch[0], 1'b0};
                    em.neg_sel = {ch[0], 1'b1};
                end else begin
                    em.pos_sel = ch;
                    em.neg_to_gnd = 1'b1;
                end
                host_u.convert();
                n_conv++;
                check("sample", {15'h0000, sample_o}, 16'h0001);
                check("mux", {6'h00, mux_o}, {6'h00, em});
                d = int'($urandom_range(18000)) - 9000;
                // Boundary points mixed in: midscale zero and the bottom of the doubled span
                if (n_conv % 3 == 0) d = 0;
                else if (n_conv % 3 == 1) d = -8192;
                code_q.push_back(int'(exp_code(d, em.pair_mode && !em.pseudo, em.range_x2,
                    res_10bit_i)));
                @(posedge ref_clk_i);
                diff_i <= 15'(d);
                diff_valid_i <= 1'b1;
                @(posedge ref_clk_i);
                diff_valid_i <= 1'b0;
                #1;
                check("code_valid", {15'h0000, code_valid_o}, 16'h0001);
                check("code", {4'h0, code_o}, 16'(code_q.pop_front()));
            end
            // Status: last channel, sequence pointer, pairing, conversion count
            host_u.rd_reg(`ACS_ADDR_STAT, q);
            check("status", q, {8'(n_conv), 3'h0, em.pair_mode, ptr, ch});
        end
        wrap_up();
    end
endmodule
